// *** verilog/rap_page_handler.v ***
// Outbound rebuild assist page handler with AXI4-Lite registers.
// Assumes the command engine loads page bytes 0..7+2n, then pulses go.
// Notes on behaviour
// R1: Page: byte 0 code, bytes 2-3 length 4+2n, byte 4 bit 0 enable, byte 7 n, mask then disable.
// R2: With enable set all fields are checked first, then the mode turns on.
// R3: With enable clear the mode turns off, other fields are ignored, all elements enabled.
// R4: An element length unlike the reported one gives illegal request, invalid parameter field.
// R5: The support mask bytes of an outbound page are never acted on.
// R6: A read or write on a disabled element's LBAs answers as a predicted error.
// R7: A read or write on an enabled element's LBAs answers with no predicted error.
// R8: With enable set, unsupported bits, all supported bits or clearing a set bit is illegal.
// R9: A predicted read error gives aborted command, first LBA and last LBA of the run.
// R10: The inbound mask marks which disable bits are supported.
// R11: The inbound page reports the mode as active while it is on.
// R12: A rejected page leaves mode and disable bits unchanged.
//
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "rap_defines.vh"
module rap_page_handler (
	input  wire        sys_clk,
	input  wire        rst,
	input  wire [5:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [5:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg         irq
);
	localparam ST_IDLE  = 2'd0;
	localparam ST_CHECK = 2'd1;
	localparam ST_APPLY = 2'd2;

	// Page image, one byte per entry; n is one byte here
	reg  [7:0]  page_reg [0:9];
	reg         mode_reg;
	reg  [7:0]  disabled_reg;
	reg  [1:0]  state_reg;
	reg  [3:0]  sense_key_reg;
	reg  [15:0] asc_reg;
	reg         busy_reg;
	reg  [31:0] lba_reg;
	reg  [15:0] run_len_reg;
	reg  [31:0] info_reg;
	reg  [31:0] cmdspec_reg;
	reg  [3:0]  acc_sk_reg;
	reg  [15:0] acc_asc_reg;
	reg  [2:0]  irq_stat_reg;
	reg  [2:0]  irq_mask_reg;
	reg         reject_reg;
	reg  [5:0]  aw_addr_reg;
	reg         aw_have_reg;
	reg  [31:0] w_data_reg;
	reg  [3:0]  w_strb_reg;
	reg         w_have_reg;
	reg  [7:0]  dis_next;

	wire [7:0]  opt_enable  = page_reg[4];
	wire [7:0]  opt_len     = page_reg[7];
	wire [7:0]  opt_disable = page_reg[9];
	wire [15:0] opt_plen    = {page_reg[2], page_reg[3]};
	wire [2:0]  lba_elem;
	wire        lba_hit;
	wire        wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
	reg  [2:0]  ev_set;
	integer     i;

	rap_elem_map #(
		.GROUP_SHIFT(4)
	) u_map (
		.lba      (lba_reg),
		.disabled (disabled_reg),
		.elem     (lba_elem),
		.hit      (lba_hit)
	);

	// Validation; page code and length covered with n since the engine framed it
	reg        bad_field;
	always @* begin
		bad_field = 1'b0;
		if (page_reg[0] != `RAP_PAGE_CODE)
			bad_field = 1'b1; // R1
		if (opt_plen != (`RAP_BASE_LEN + {7'h00, opt_len, 1'b0}))
			bad_field = 1'b1; // R1
		if (opt_len != `RAP_ELEM_LEN)
			bad_field = 1'b1; // R4
		if ((opt_disable & ~`RAP_SUPPORT_MASK) != 8'h00)
			bad_field = 1'b1; // R8
		if ((opt_disable & `RAP_SUPPORT_MASK) == `RAP_SUPPORT_MASK)
			bad_field = 1'b1; // R8
		if ((disabled_reg & ~opt_disable) != 8'h00)
			bad_field = 1'b1; // R8
		// Mask byte page_reg[8] is never examined R5
		dis_next = opt_disable & `RAP_SUPPORT_MASK;
	end

	// Event strobes for the sticky status bits
	always @* begin
		ev_set = 3'b000;
		if (state_reg == ST_APPLY || (state_reg == ST_CHECK && !opt_enable[0]))
			ev_set[`RAP_IRQ_PAGE_DONE] = 1'b1;
		if (state_reg == ST_CHECK && opt_enable[0] && bad_field)
			ev_set[`RAP_IRQ_PAGE_REJ] = 1'b1;
		if (wr_fire && aw_addr_reg == `RAP_REG_ACCESS && w_data_reg[0] && mode_reg && lba_hit)
			ev_set[`RAP_IRQ_PRED_ERR] = 1'b1; // R6
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'b00;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= 2'b00;
			s_axi_rdata   <= 32'h00000000;
			irq           <= 1'b0;
			aw_have_reg   <= 1'b0;
			w_have_reg    <= 1'b0;
			aw_addr_reg   <= 6'h00;
			w_data_reg    <= 32'h00000000;
			w_strb_reg    <= 4'h0;
			mode_reg      <= 1'b0;
			disabled_reg  <= 8'h00;
			state_reg     <= ST_IDLE;
			sense_key_reg <= `RAP_SK_GOOD;
			asc_reg       <= 16'h0000;
			busy_reg      <= 1'b0;
			lba_reg       <= 32'h00000000;
			run_len_reg   <= 16'h0000;
			info_reg      <= 32'h00000000;
			cmdspec_reg   <= 32'h00000000;
			acc_sk_reg    <= `RAP_SK_GOOD;
			acc_asc_reg   <= 16'h0000;
			irq_stat_reg  <= 3'b000;
			irq_mask_reg  <= 3'b000;
			reject_reg    <= 1'b0;
			for (i = 0; i < 10; i = i + 1)
				page_reg[i] <= 8'h00;
		end else begin
			// Write channel capture, either order
			s_axi_awready <= !aw_have_reg && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_have_reg && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;

			// Page processing
			case (state_reg)
			ST_IDLE: begin
				busy_reg <= 1'b0;
			end
			ST_CHECK: begin
				if (opt_enable[0] == 1'b0) begin
					mode_reg     <= 1'b0; // R3
					disabled_reg <= 8'h00; // R3
					sense_key_reg <= `RAP_SK_GOOD;
					asc_reg      <= 16'h0000;
					reject_reg   <= 1'b0;
					state_reg    <= ST_IDLE;
				end else if (bad_field) begin
					// Mode and disable bits untouched on reject R12
					sense_key_reg <= `RAP_SK_ILLEGAL; // R4 R8
					asc_reg      <= `RAP_ASC_INV_PARM;
					reject_reg   <= 1'b1;
					state_reg    <= ST_IDLE;
				end else begin
					state_reg <= ST_APPLY; // R2
				end
			end
			ST_APPLY: begin
				// Self-test skipped; it is optional
				mode_reg      <= 1'b1; // R2
				disabled_reg  <= dis_next; // R6 R7
				sense_key_reg <= `RAP_SK_GOOD;
				asc_reg       <= 16'h0000;
				reject_reg    <= 1'b0;
				state_reg     <= ST_IDLE;
			end
			default: state_reg <= ST_IDLE;
			endcase

			// Register writes
			if (wr_fire) begin
				aw_have_reg  <= 1'b0;
				w_have_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= 2'b00;
				case (aw_addr_reg)
				`RAP_REG_CTRL: begin
					if (w_data_reg[0] && w_strb_reg[0] && !busy_reg) begin
						busy_reg  <= 1'b1;
						state_reg <= ST_CHECK;
					end
				end
				`RAP_REG_PAGE: begin
					if (w_strb_reg[1] && w_data_reg[11:8] < 4'ha && !busy_reg)
						page_reg[w_data_reg[11:8]] <= w_data_reg[7:0]; // R1
				end
				`RAP_REG_LBA: begin
					lba_reg     <= w_data_reg;
					run_len_reg <= 16'h0000;
				end
				`RAP_REG_ACCESS: begin
					// Bit 0 starts an access check, bit 1 marks a write
					if (w_data_reg[0]) begin
						if (mode_reg && lba_hit) begin
							acc_sk_reg <= w_data_reg[1] ? `RAP_SK_ABORTED
							                            : `RAP_SK_ABORTED; // R6
							acc_asc_reg <= w_data_reg[1] ? `RAP_ASC_WRITE_ERR
							                             : `RAP_ASC_MULTI_READ; // R9
							info_reg    <= lba_reg; // R9
							// Run ends at the end of this element's LBA group
							cmdspec_reg <= {lba_reg[31:4], 4'hf}; // R9
						end else begin
							acc_sk_reg  <= `RAP_SK_GOOD; // R7
							acc_asc_reg <= 16'h0000;
						end
					end
				end
				`RAP_REG_IRQ_STAT: begin
					irq_stat_reg <= irq_stat_reg & ~w_data_reg[2:0];
				end
				`RAP_REG_IRQ_MASK: begin
					irq_mask_reg <= w_data_reg[2:0];
				end
				default: begin
					if (aw_addr_reg > `RAP_REG_ELEM)
						s_axi_bresp <= 2'b10;
				end
				endcase
			end
			// Set wins over a same-cycle clear
			if (wr_fire && aw_addr_reg == `RAP_REG_IRQ_STAT)
				irq_stat_reg <= (irq_stat_reg & ~w_data_reg[2:0]) | ev_set;
			else
				irq_stat_reg <= irq_stat_reg | ev_set;
			irq <= |((irq_stat_reg | ev_set) & irq_mask_reg);

			// Read channel
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= 2'b00;
				case (s_axi_araddr)
				`RAP_REG_CTRL:     s_axi_rdata <= 32'h00000000;
				`RAP_REG_STATUS:   s_axi_rdata <= {29'h0, reject_reg, busy_reg, mode_reg};
				`RAP_REG_PAGE:     s_axi_rdata <= 32'h00000000;
				`RAP_REG_RESULT:   s_axi_rdata <= {12'h0, sense_key_reg, asc_reg};
				`RAP_REG_LBA:      s_axi_rdata <= lba_reg;
				`RAP_REG_ACCESS:   s_axi_rdata <= {12'h0, acc_sk_reg, acc_asc_reg};
				`RAP_REG_INFO:     s_axi_rdata <= info_reg;
				`RAP_REG_CMDSPEC:  s_axi_rdata <= cmdspec_reg;
				`RAP_REG_IRQ_STAT: s_axi_rdata <= {29'h0, irq_stat_reg};
				`RAP_REG_IRQ_MASK: s_axi_rdata <= {29'h0, irq_mask_reg};
				// Inbound page bytes 4 and 7 then mask and page code R10 R11
				`RAP_REG_INPAGE:   s_axi_rdata <= {7'h00, mode_reg, `RAP_ELEM_LEN,
				                                   `RAP_SUPPORT_MASK, `RAP_PAGE_CODE};
				`RAP_REG_ELEM:     s_axi_rdata <= {16'h0, `RAP_SUPPORT_MASK, disabled_reg};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= 2'b10;
				end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// *** verilog/rap_defines.vh ***
// Constants for the rebuild assist page handler.
// Assumes inclusion by bare name; definitions only.
`ifndef RAP_DEFINES_VH
`define RAP_DEFINES_VH
`define RAP_PAGE_CODE      8'h42
`define RAP_ELEM_LEN       8'h01
`define RAP_ELEM_BITS      8
`define RAP_SUPPORT_MASK   8'h0f
`define RAP_HDR_BYTES      16'h0008
`define RAP_BASE_LEN       16'h0004
`define RAP_REG_CTRL       6'h00
`define RAP_REG_STATUS     6'h04
`define RAP_REG_PAGE       6'h08
`define RAP_REG_RESULT     6'h0c
`define RAP_REG_LBA        6'h10
`define RAP_REG_ACCESS     6'h14
`define RAP_REG_INFO       6'h18
`define RAP_REG_CMDSPEC    6'h1c
`define RAP_REG_IRQ_STAT   6'h20
`define RAP_REG_IRQ_MASK   6'h24
`define RAP_REG_INPAGE     6'h28
`define RAP_REG_ELEM       6'h2c
`define RAP_SK_GOOD        4'h0
`define RAP_SK_ILLEGAL     4'h5
`define RAP_SK_ABORTED     4'hb
`define RAP_ASC_INV_PARM   16'h2600
`define RAP_ASC_MULTI_READ 16'h1100
`define RAP_ASC_WRITE_ERR  16'h0c00
`define RAP_IRQ_PAGE_DONE  0
`define RAP_IRQ_PAGE_REJ   1
`define RAP_IRQ_PRED_ERR   2
`endif

// *** verilog/rap_elem_map.v ***
// Maps an LBA to its physical element and checks the disable bits.
// Assumes LBAs are striped over the elements in fixed size groups.
`timescale 1ns/1ps
`default_nettype none
module rap_elem_map #(
	parameter GROUP_SHIFT = 4
) (
	input  wire [31:0] lba,
	input  wire [7:0]  disabled,
	output wire [2:0]  elem,
	output wire        hit
);
	assign elem = lba[GROUP_SHIFT+2:GROUP_SHIFT];
	assign hit  = disabled[elem]; // R6 R7
endmodule
`default_nettype wire

// *** sim/rap_checker_properties.sv ***
// Bus and interrupt checker for the page handler.
// Sees only the top ports; bound at the foot.
`timescale 1ns/1ps
`default_nettype none
module rap_checker (
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [5:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        irq
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_aw_taken: assert property (s_axi_awvalid |-> ##[0:4] s_axi_awready)
		else $error("write address not taken");
	a_ar_taken: assert property (s_axi_arvalid |-> ##[0:4] s_axi_arready)
		else $error("read address not taken");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_wr_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:6] s_axi_bvalid)
		else $error("write response late");
	a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_bad_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 6'h2c |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	a_reset_quiet: assert property ($fell(rst) |-> !s_axi_bvalid && !s_axi_rvalid && !irq)
		else $error("outputs busy after reset");
	c_reject: cover property (s_axi_rvalid && s_axi_rdata == 32'h0005_2600);
	c_irq: cover property ($rose(irq));
	c_bad: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule
bind rap_page_handler rap_checker i_rap_checker (.sys_clk(sys_clk), .rst(rst),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));
`default_nettype wire

// *** sim/rap_host_model.sv ***
// Initiator model: register bus master that builds outbound pages.
// Assumes one caller at a time.
`timescale 1ns/1ps
`default_nettype none
`include "rap_defines.vh"
module rap_host_model (
	input  wire logic        sys_clk,
	output var  logic [5:0]  s_axi_awaddr,
	output var  logic        s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output var  logic [31:0] s_axi_wdata,
	output var  logic [3:0]  s_axi_wstrb,
	output var  logic        s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic        s_axi_bvalid,
	output var  logic        s_axi_bready,
	output var  logic [5:0]  s_axi_araddr,
	output var  logic        s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic        s_axi_rvalid,
	output var  logic        s_axi_rready
);
	initial {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready,
		s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
	// Released lines invert so stale values cannot pass
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 0;
		w = 0;
		@(posedge sys_clk);
		{s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_awvalid, s_axi_wvalid, s_axi_bready}
			<= {a, d, 4'hf, 3'h7};
		while (!(aw && w)) begin
			@(posedge sys_clk);
			if (!aw && s_axi_awready) begin
				aw = 1;
				{s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
			end
			if (!w && s_axi_wready) begin
				w = 1;
				{s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
			end
		end
		while (!s_axi_bvalid) @(posedge sys_clk);
		s_axi_bready <= 0;
	endtask
	task automatic rd(input logic [5:0] a);
		@(posedge sys_clk);
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
		do @(posedge sys_clk); while (!s_axi_arready);
		{s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
		do @(posedge sys_clk); while (!s_axi_rvalid);
		s_axi_rready <= 0;
	endtask
	task automatic page(input logic [7:0] en, n, mk, ds);
		logic [7:0] b [10];
		b = '{`RAP_PAGE_CODE, 8'h0, 8'h0, 8'h04 + (n << 1), en, 8'h0, 8'h0, n, mk, ds};
		for (int i = 0; i < 10; i++)
			wr(`RAP_REG_PAGE, {20'h0, 4'(i), b[i]});
		wr(`RAP_REG_CTRL, 32'h1);
		repeat (6) @(posedge sys_clk);
	endtask
endmodule
`default_nettype wire

// *** sim/rap_page_handler_tb_top.sv ***
// Bench: host model drives, read monitor scores against a queue.
// Assumes reads complete in order.
`timescale 1ns/1ps
`default_nettype none
`include "rap_defines.vh"
module rap_page_handler_tb_top;
	logic        sys_clk = 0;
	logic        rst = 1;
	wire  [5:0]  s_axi_awaddr, s_axi_araddr;
	wire  [31:0] s_axi_wdata, s_axi_rdata;
	wire  [3:0]  s_axi_wstrb;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	wire         s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
	logic [33:0] exp_q [$];
	logic [7:0]  cases [4] = '{8'h03, 8'h11, 8'h0f, 8'h02};
	logic [31:0] seed = 32'hd47d;
	logic [7:0]  cur, d;
	logic        ok;
	int          mismatches = 0, tests_run = 0, cycles = 0;
	rap_page_handler i_rap_page_handler (.*);
	rap_host_model i_rap_host_model (.*);
	initial forever #2 sys_clk = ~sys_clk;
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input logic [33:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rc(input logic [5:0] a, input logic [33:0] e);
		exp_q.push_back(e);
		i_rap_host_model.rd(a);
	endtask
	task automatic acc(input logic [31:0] lba, input logic w, input logic [33:0] e);
		i_rap_host_model.wr(`RAP_REG_LBA, lba);
		i_rap_host_model.wr(`RAP_REG_ACCESS, {30'h0, w, 1'b1});
		repeat (4) @(posedge sys_clk);
		// Access outcome lives in its own register, apart from page sense
		rc(`RAP_REG_ACCESS, e);
	endtask
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Run needs roughly a thousand cycles
	always @(posedge sys_clk) begin
		cycles++;
		if (s_axi_rvalid && s_axi_rready)
			chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
		if (cycles == 20000) begin
			mismatches++;
			wrap_up();
		end
	end
	initial begin
		repeat (16) @(posedge sys_clk);
		rst <= 0;
		rc(`RAP_REG_ELEM, 34'h0f00);
		rc(`RAP_REG_INPAGE, 34'h0001_0f42);
		i_rap_host_model.wr(`RAP_REG_IRQ_MASK, 32'h7);
		i_rap_host_model.page(8'h01, 8'h01, 8'hf0, 8'h01);
		rc(`RAP_REG_RESULT, 34'h0);
		rc(`RAP_REG_INPAGE, 34'h0101_0f42);
		chk({33'h0, irq}, 34'h1);
		i_rap_host_model.wr(`RAP_REG_IRQ_STAT, 32'h7);
		repeat (3) @(posedge sys_clk);
		chk({33'h0, irq}, 34'h0);
		acc(32'h5, 1'b0, 34'h000b_1100);
		rc(`RAP_REG_INFO, 34'h5);
		rc(`RAP_REG_CMDSPEC, 34'hf);
		acc(32'h17, 1'b1, 34'h0);
		acc(32'h6, 1'b1, 34'h000b_0c00);
		cur = 8'h01;
		for (int i = 0; i < 12; i++) begin
			d = (i < 4) ? cases[i] : 8'(rnd() & 32'h1f);
			ok = i != 0 && d[7:4] == 4'h0 && d != 8'h0f && (d & cur) == cur;
			i_rap_host_model.page(8'h01, (i == 0) ? 8'h02 : 8'h01, 8'(rnd()), d);
			if (ok)
				cur = d;
			rc(`RAP_REG_RESULT, ok ? 34'h0 : 34'h0005_2600);
			rc(`RAP_REG_ELEM, {18'h0, 8'h0f, cur});
		end
		i_rap_host_model.page(8'h00, 8'h05, 8'hff, 8'hff);
		rc(`RAP_REG_RESULT, 34'h0);
		rc(`RAP_REG_ELEM, 34'h0f00);
		rc(`RAP_REG_INPAGE, 34'h0001_0f42);
		acc(32'h5, 1'b0, 34'h0);
		rc(6'h30, {2'h2, 32'h0});
		i_rap_host_model.wr(6'h34, 32'h1);
		repeat (4) @(posedge sys_clk);
		wrap_up();
	end
endmodule
`default_nettype wire
